// ==== hdl/lbsc_top.sv ====
// Local bus SRAM controller with burst counter, bus arbiter and select decode.
// Assumes every local bus and SRAM pin is synchronous to sys_clk, so no
// synchronisers are placed on them, and a pipelined SRAM with one cycle latency.
`timescale 1ns/1ns
`default_nettype none
module lbsc_top #(
   parameter bit STOP_AT_PAGE_END = 1'b1,
   parameter bit MIRROR_AT_ZERO = 1'b0
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire lbsc_pkg::lbsc_local_req_type local_req,
   input wire logic [31:0] local_data_bus_in,
   output logic [31:0] local_data_bus_out,
   output logic local_data_oe_n,
   output logic ready_n,
   output logic burst_stop_n,
   input wire logic bridge_hold_req,
   input wire logic [1:0] master_request,
   output logic bridge_hold_ack,
   output logic [1:0] master_grant,
   output logic option_module_select_n,
   output logic [2:0] spare_select_n,
   output logic mem_select_n,
   output logic mem_out_en_n,
   output logic [3:0] mem_byte_wr_en_n,
   output logic [14:0] mem_word_addr,
   input wire logic [31:0] mem_rd_data,
   output logic [31:0] mem_wr_data,
   output logic mem_data_oe_n
);
   import lbsc_pkg::*;

   // Sequencer and SRAM pin registers.
   lbsc_state_type state_reg;
   lbsc_state_type state_next;
   lbsc_mem_ctrl_type mem_ctrl_reg;
   lbsc_mem_ctrl_type mem_ctrl_next;

   // Burst address register: page and counter.
   logic [PAGE_BITS-1:0] page_reg;
   logic [PAGE_BITS-1:0] page_next;
   logic [CNT_BITS-1:0] cnt_reg;
   logic [CNT_BITS-1:0] cnt_next;

   // Write data and read-back registers.
   logic [31:0] mem_wr_data_reg;
   logic [31:0] mem_wr_data_next;
   logic [31:0] local_rd_reg;

   // Decode and sequencing terms.
   wire [31:0] addr = local_req.local_addr;
   wire [3:0] top_nibble = addr[31:28];
   wire sram_hit;
   wire mirror_hit;
   wire start_hit;
   wire wr_go;
   wire rd_issue_go;
   wire phase_done;
   wire at_page_end;
   wire stop_now;
   wire burst_end;

   // Read buffer handshake.
   wire buf_in_valid;
   wire buf_in_ready;
   wire buf_out_valid;
   wire buf_out_ready;
   wire [31:0] buf_out_data;

   // Burst address terms.
   wire [WORD_ADDR_BITS-1:0] cur_word_addr;
   wire [CNT_BITS-1:0] cnt_inc;

   // Address decode. The peripheral selects are partial decodes of the top nibble only, so
   // each of them repeats throughout its 256 MB region; the SRAM window is exact.
   assign sram_hit = lbsc_in_window(addr, SRAM_BASE, SRAM_LAST);
   assign mirror_hit = MIRROR_AT_ZERO && lbsc_in_window(addr, MIRROR_BASE, MIRROR_LAST);
   assign start_hit = !local_req.addr_strobe_n && (sram_hit || mirror_hit);
   assign option_module_select_n = !(top_nibble == OPTION_NIBBLE);
   assign spare_select_n[0] = !(top_nibble == SPARE1_NIBBLE);
   assign spare_select_n[1] = !(top_nibble == SPARE2_NIBBLE);
   assign spare_select_n[2] = !(top_nibble == SPARE3_NIBBLE);

   // The SRAM address is the page plus the burst counter, never the bus.
   assign cur_word_addr = {page_reg, cnt_reg};
   assign cnt_inc = cnt_reg + CNT_STEP;
   assign at_page_end = (cnt_reg == CNT_ALL_ONES);

   // A data phase completes when the controller answers and the bridge is
   // not inserting a wait state on its side.
   assign wr_go = (state_reg == LBSC_WR_PHASE) && local_req.accept;
   assign rd_issue_go = (state_reg == LBSC_RD_ISSUE) && buf_in_ready;
   assign buf_out_ready = (state_reg == LBSC_RD_PRESENT) && local_req.accept;
   assign phase_done = wr_go || (buf_out_valid && buf_out_ready);

   // Burst stop is raised only with the completing phase at the last page
   // word; with the option off it never moves, and masters must then keep
   // their bursts inside one page or the early words get overwritten.
   assign stop_now = STOP_AT_PAGE_END && at_page_end && phase_done;
   assign burst_stop_n = !stop_now;
   assign burst_end = phase_done && (!local_req.last_n || stop_now);

   // Ready is a combinational handshake toward the bridge.
   assign ready_n = !phase_done;

   // Read words are pushed into the buffer in the cycle the SRAM drives them.
   assign buf_in_valid = (state_reg == LBSC_RD_CAP);

   // Read data toward the bridge is driven only while a read phase is open.
   assign local_data_bus_out = buf_out_data;
   assign local_data_oe_n = !((state_reg == LBSC_RD_PRESENT) && buf_out_valid);

   // SRAM pins are taken straight from registers.
   assign mem_select_n = mem_ctrl_reg.sel_n;
   assign mem_out_en_n = mem_ctrl_reg.oe_n;
   assign mem_byte_wr_en_n = mem_ctrl_reg.byte_wr_en_n;
   assign mem_word_addr = mem_ctrl_reg.word_addr;
   assign mem_data_oe_n = mem_ctrl_reg.data_oe_n;
   assign mem_wr_data = mem_wr_data_reg;

   // Sequencer. A burst becomes a chain of single SRAM cycles; reads are
   // not prefetched, which costs throughput but keeps the counter exactly
   // in step with the completed phases.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         LBSC_IDLE: begin
            if (start_hit) begin
               state_next = local_req.write ? LBSC_WR_PHASE : LBSC_RD_ISSUE;
            end
         end
         LBSC_RD_ISSUE: begin
            if (rd_issue_go) begin
               state_next = LBSC_RD_ADDR;
            end
         end
         LBSC_RD_ADDR: state_next = LBSC_RD_CAP;
         LBSC_RD_CAP: state_next = LBSC_RD_PRESENT;
         LBSC_RD_PRESENT: begin
            if (burst_end) begin
               state_next = LBSC_IDLE;
            end else if (phase_done) begin
               state_next = LBSC_RD_ISSUE;
            end
         end
         LBSC_WR_PHASE: begin
            if (burst_end) begin
               state_next = LBSC_IDLE;
            end
         end
         default: state_next = LBSC_IDLE;
      endcase
   end

   // Address register: loaded at the strobe, counter stepped per phase.
   always_comb begin
      page_next = page_reg;
      cnt_next = cnt_reg;
      if ((state_reg == LBSC_IDLE) && start_hit) begin
         page_next = addr[WORD_ADDR_MSB -: PAGE_BITS];
         cnt_next = addr[WORD_ADDR_LSB +: CNT_BITS];
      end else if (phase_done) begin
         cnt_next = cnt_inc;
      end
   end

   // SRAM control word for the next cycle. Output enable is kept on through
   // the data cycle so that the pipelined read word is on the pins.
   always_comb begin
      mem_ctrl_next = MEM_CTRL_IDLE;
      mem_wr_data_next = mem_wr_data_reg;
      if (rd_issue_go) begin
         mem_ctrl_next.sel_n = 1'b0;
         mem_ctrl_next.oe_n = 1'b0;
         mem_ctrl_next.word_addr = cur_word_addr;
      end else if (state_reg == LBSC_RD_ADDR) begin
         mem_ctrl_next.oe_n = 1'b0;
      end else if (wr_go) begin
         mem_ctrl_next.sel_n = 1'b0;
         mem_ctrl_next.data_oe_n = 1'b0;
         mem_ctrl_next.byte_wr_en_n = local_req.byte_en_n;
         mem_ctrl_next.word_addr = cur_word_addr;
         mem_wr_data_next = local_data_bus_in;
      end
   end

   // State and address registers on the single bus clock; the board reset
   // brings the whole block back to idle.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg <= LBSC_IDLE;
         page_reg <= PAGE_RESET;
         cnt_reg <= CNT_RESET;
      end else begin
         state_reg <= state_next;
         page_reg <= page_next;
         cnt_reg <= cnt_next;
      end
   end

   // SRAM pin registers; reset leaves select and write enables inactive.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mem_ctrl_reg <= MEM_CTRL_IDLE;
         mem_wr_data_reg <= '0;
      end else begin
         mem_ctrl_reg <= mem_ctrl_next;
         mem_wr_data_reg <= mem_wr_data_next;
      end
   end

   // Last read word seen, kept only for the assertions below.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         local_rd_reg <= '0;
      end else if (buf_in_valid) begin
         local_rd_reg <= mem_rd_data;
      end
   end

   // Read buffer: a receiver stall holds words here instead of losing them.
   lbsc_buf2 #(
      .WIDTH(DATA_W),
      .DEPTH(BUF_DEPTH)
   ) u_rd_buf (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(mem_rd_data),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   // Bus arbiter.
   lbsc_arbiter u_arbiter (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .bridge_hold_req(bridge_hold_req),
      .master_request(master_request),
      .bridge_hold_ack(bridge_hold_ack),
      .master_grant(master_grant)
   );

   default clocking top_cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Read issue: select with enable, then enable alone.
   read_issue_pins_a: assert property (rd_issue_go |=> !mem_select_n && !mem_out_en_n ##1
      mem_select_n && !mem_out_en_n)
      else $error("SRAM read controls wrong after issue.");

   // The strobe loads page and counter.
   start_capture_a: assert property ((state_reg == LBSC_IDLE) && start_hit |=>
      cur_word_addr == $past(addr[WORD_ADDR_MSB:WORD_ADDR_LSB]))
      else $error("Start address not captured.");

   // The SRAM address is the register of the cycle before.
   word_addr_src_a: assert property (!mem_select_n |-> mem_word_addr == $past(cur_word_addr))
      else $error("SRAM address not from the address register.");

   // A phase that does not end the burst steps.
   count_step_a: assert property (phase_done && !burst_end |=>
      cnt_reg == $past(cnt_reg) + CNT_STEP)
      else $error("Burst counter did not step.");

   // Page bits change only at a new start.
   page_fixed_a: assert property ((state_reg != LBSC_IDLE) && ($past(state_reg) != LBSC_IDLE)
      |-> $stable(page_reg))
      else $error("Page bits changed inside a burst.");

   // The page end is followed by word zero.
   wrap_zero_a: assert property (phase_done && at_page_end |=> cnt_reg == CNT_RESET)
      else $error("Counter did not wrap to zero.");

   // Burst stop marks only the page-end phase.
   stop_page_end_a: assert property (!burst_stop_n |-> STOP_AT_PAGE_END && phase_done &&
      at_page_end ##1 state_reg == LBSC_IDLE)
      else $error("Burst stop outside the page end.");

   // Reads take three cycles from issue.
   read_latency_a: assert property (rd_issue_go |-> ##3 (state_reg == LBSC_RD_PRESENT) &&
      buf_out_valid && buf_out_data == local_rd_reg)
      else $error("Read word not presented three cycles after issue.");

   // Ready comes only from a phase state.
   ready_decoded_a: assert property (!ready_n |-> (state_reg == LBSC_WR_PHASE) ||
      (state_reg == LBSC_RD_PRESENT))
      else $error("Ready without a decoded burst.");

   // An undecoded strobe leaves the sequencer idle.
   undecoded_idle_a: assert property ((state_reg == LBSC_IDLE) && !start_hit |=>
      state_reg == LBSC_IDLE)
      else $error("Undecoded strobe started a burst.");

   // A marked last phase returns to idle.
   burst_end_idle_a: assert property (phase_done && !local_req.last_n |=>
      state_reg == LBSC_IDLE)
      else $error("Burst did not end at its last phase.");

   // Each write phase is one SRAM write.
   write_pulse_a: assert property (wr_go |=> !mem_select_n && !mem_data_oe_n &&
      mem_byte_wr_en_n == $past(local_req.byte_en_n))
      else $error("Write phase did not give a single SRAM write.");

   // Write data is the word of the phase.
   write_data_a: assert property (wr_go |=> mem_wr_data == $past(local_data_bus_in))
      else $error("SRAM write data not from the phase.");

   // No byte write without a write phase.
   write_only_phase_a: assert property (!wr_go |=> mem_byte_wr_en_n == BYTE_EN_NONE_N)
      else $error("SRAM byte write outside a write phase.");

   // Two idle cycles leave the SRAM deselected.
   idle_quiet_a: assert property ((state_reg == LBSC_IDLE) && $past(state_reg == LBSC_IDLE)
      |-> mem_select_n && mem_out_en_n)
      else $error("SRAM selected while the sequencer idles.");

   // The counter holds in wait states.
   wait_hold_a: assert property ((state_reg != LBSC_IDLE) && !phase_done |=> $stable(cnt_reg))
      else $error("Counter moved during a wait state.");

   // Reset idles the SRAM side, ready and the hold acknowledge.
   reset_idle_a: assert property (@(posedge sys_clk) disable iff (1'b0) !rst_n |=>
      mem_select_n && mem_byte_wr_en_n == BYTE_EN_NONE_N && ready_n && !bridge_hold_ack)
      else $error("Reset did not idle the SRAM side.");

   // Main scenarios for coverage.
   read_burst_c: cover property (phase_done && (state_reg == LBSC_RD_PRESENT) ##1 rd_issue_go);
   write_burst_c: cover property (wr_go ##1 wr_go ##1 wr_go);
   page_stop_c: cover property (!burst_stop_n);
   read_stall_c: cover property ((state_reg == LBSC_RD_PRESENT) && buf_out_valid &&
      !local_req.accept [*2]);
   undecoded_c: cover property ((state_reg == LBSC_IDLE) && !local_req.addr_strobe_n && !start_hit);
endmodule : lbsc_top
`default_nettype wire

// ==== hdl/lbsc_pkg.sv ====
// Shared constants, types and helper functions for the local bus SRAM controller.
// Assumes one synchronous local bus clock and a synchronous active-low reset.
// Summary of operation
// - Drive SRAM select, output enable and four byte write enables per SRAM cycle.
// - Capture fifteen word address bits when address strobe is low.
// - SRAM word address comes from the internal address register only.
// - Low eleven captured bits form a counter stepping the burst address.
// - Upper four captured bits stay fixed; SRAM acts as sixteen pages.
// - Counter wraps from all ones to zero inside the same page.
// - Burst stop stays inactive unless the page-end option is enabled.
// - Optionally assert burst stop when all eleven counter bits are ones.
// - Each burst data phase is one single SRAM read or write.
// - Each served memory cycle ends with the active-low ready signal.
// - Undecoded addresses receive no ready, leaving the bus waiting.
// - Optional mirror of the SRAM at address zero for boot reads.
// - Arbiter takes two master requests plus the bridge hold request.
// - One grant per master plus hold acknowledge; one owner at once.
// - Four active-low peripheral selects decoded from top four address bits.
// - Option module select active for 4000_0000 through 4FFF_FFFF.
// - All logic runs on the single shared local bus clock.
// - SRAM select window is 2000_0000 through 2001_FFFF with byte writes.
// - Board reset clears the local side logic including this block.
package lbsc_pkg;

   localparam int DATA_W = 32;
   localparam int BUF_DEPTH = 2;
   localparam int WORD_ADDR_LSB = 2;
   localparam int WORD_ADDR_MSB = 16;
   localparam int CNT_BITS = 11;
   localparam int PAGE_BITS = 4;
   localparam int WORD_ADDR_BITS = PAGE_BITS + CNT_BITS;

   localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
   localparam logic [31:0] SRAM_LAST = 32'h2001_FFFF;
   localparam logic [31:0] MIRROR_BASE = 32'h0000_0000;
   localparam logic [31:0] MIRROR_LAST = 32'h0001_FFFF;
   localparam logic [3:0] OPTION_NIBBLE = 4'h4;
   localparam logic [3:0] SPARE1_NIBBLE = 4'h5;
   localparam logic [3:0] SPARE2_NIBBLE = 4'h6;
   localparam logic [3:0] SPARE3_NIBBLE = 4'h7;

   localparam logic [CNT_BITS-1:0] CNT_ALL_ONES = 11'h7FF;
   localparam logic [CNT_BITS-1:0] CNT_RESET = 11'h000;
   localparam logic [CNT_BITS-1:0] CNT_STEP = 11'h001;
   localparam logic [PAGE_BITS-1:0] PAGE_RESET = 4'h0;
   localparam logic [3:0] BYTE_EN_NONE_N = 4'hF;

   // Controller states.
   typedef enum logic [2:0] {
      LBSC_IDLE = 3'b000,
      LBSC_RD_ISSUE = 3'b001,
      LBSC_RD_ADDR = 3'b010,
      LBSC_RD_CAP = 3'b011,
      LBSC_RD_PRESENT = 3'b100,
      LBSC_WR_PHASE = 3'b101
   } lbsc_state_type;

   // Arbiter owners.
   typedef enum logic [1:0] {
      LBSC_OWN_NONE = 2'b00,
      LBSC_OWN_BRIDGE = 2'b01,
      LBSC_OWN_M0 = 2'b10,
      LBSC_OWN_M1 = 2'b11
   } lbsc_owner_type;

   // Request side of the local bus as seen by the controller.
   typedef struct packed {
      logic [31:0] local_addr;
      logic addr_strobe_n;
      logic write;
      logic [3:0] byte_en_n;
      logic last_n;
      logic accept;
   } lbsc_local_req_type;

   // Control word driven toward the synchronous SRAM.
   typedef struct packed {
      logic sel_n;
      logic oe_n;
      logic data_oe_n;
      logic [3:0] byte_wr_en_n;
      logic [WORD_ADDR_BITS-1:0] word_addr;
   } lbsc_mem_ctrl_type;

   localparam lbsc_mem_ctrl_type MEM_CTRL_IDLE = '{
      sel_n: 1'b1, oe_n: 1'b1, data_oe_n: 1'b1,
      byte_wr_en_n: BYTE_EN_NONE_N, word_addr: '0};

   // Inclusive address window test, used for the SRAM and mirror ranges.
   function automatic logic lbsc_in_window(input logic [31:0] addr,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi);
      lbsc_in_window = (addr >= lo) && (addr <= hi);
   endfunction : lbsc_in_window

endpackage : lbsc_pkg

// ==== hdl/lbsc_buf2.sv ====
// Two-entry valid/ready buffer that carries SRAM read words to the local bus.
// Assumes both sides run on the same clock; full and empty are exact.
`timescale 1ns/1ns
`default_nettype none
module lbsc_buf2 #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W:0] COUNT_FULL = (PTR_W + 1)'(DEPTH);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] store_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W:0] count_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Full and empty come straight from the occupancy count.
   assign in_ready = (count_reg != COUNT_FULL);
   assign out_valid = (count_reg != '0);
   assign out_data = store_reg[rd_ptr_reg];

   // Pointers wrap at the depth; storage itself needs no reset.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
      end
   end

   // Data write port.
   always_ff @(posedge sys_clk) begin
      if (push) begin
         store_reg[wr_ptr_reg] <= in_data;
      end
   end

   default clocking buf_cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   buf_no_overflow_a: assert property (count_reg <= COUNT_FULL)
      else $error("Read buffer count above depth.");
endmodule : lbsc_buf2
`default_nettype wire

// ==== hdl/lbsc_arbiter.sv ====
// External local bus arbiter: bridge hold request plus two master requests.
// Assumes requesters hold their request for the whole tenure.
`timescale 1ns/1ns
`default_nettype none
module lbsc_arbiter (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic bridge_hold_req,
   input wire logic [1:0] master_request,
   output logic bridge_hold_ack,
   output logic [1:0] master_grant
);
   import lbsc_pkg::*;

   lbsc_owner_type owner_reg;
   lbsc_owner_type owner_next;
   logic owner_still_wants;

   // The current owner keeps the bus while it asks; a drop frees it for a cycle.
   assign owner_still_wants = (owner_reg == LBSC_OWN_BRIDGE) ? bridge_hold_req :
                              (owner_reg == LBSC_OWN_M0) ? master_request[0] :
                              (owner_reg == LBSC_OWN_M1) ? master_request[1] : 1'b0;

   // Fixed priority on a free bus: bridge first, then master 0, then master 1.
   always_comb begin
      owner_next = owner_reg;
      case (owner_reg)
         LBSC_OWN_NONE: begin
            if (bridge_hold_req) begin
               owner_next = LBSC_OWN_BRIDGE;
            end else if (master_request[0]) begin
               owner_next = LBSC_OWN_M0;
            end else if (master_request[1]) begin
               owner_next = LBSC_OWN_M1;
            end
         end
         LBSC_OWN_BRIDGE, LBSC_OWN_M0, LBSC_OWN_M1: begin
            if (!owner_still_wants) begin
               owner_next = LBSC_OWN_NONE;
            end
         end
         default: owner_next = LBSC_OWN_NONE;
      endcase
   end

   // Grants decode from the owner register, so at most one is ever high.
   assign bridge_hold_ack = (owner_reg == LBSC_OWN_BRIDGE);
   assign master_grant[0] = (owner_reg == LBSC_OWN_M0);
   assign master_grant[1] = (owner_reg == LBSC_OWN_M1);

   // Owner register; reset leaves every grant low.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         owner_reg <= LBSC_OWN_NONE;
      end else begin
         owner_reg <= owner_next;
      end
   end

   default clocking arb_cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   grant_one_hot_a: assert property ($onehot0({bridge_hold_ack, master_grant}))
      else $error("More than one bus grant active.");
   grant_follows_req_a: assert property (master_grant[0] |-> $past(master_request[0]))
      else $error("Master 0 granted without a request.");
endmodule : lbsc_arbiter
`default_nettype wire

// ==== bench/lbsc_sram_model.sv ====
// Behavioural pipelined synchronous SRAM, 32K words with byte writes.
// Assumes the controller changes select, enables and address only at sys_clk edges.
`timescale 1ns/1ns
`default_nettype none
module lbsc_sram_model (
   input wire logic sys_clk,
   input wire logic mem_select_n,
   input wire logic mem_out_en_n,
   input wire logic [3:0] mem_byte_wr_en_n,
   input wire logic [14:0] mem_word_addr,
   input wire logic [31:0] mem_wr_data,
   output logic [31:0] mem_rd_data
);
   logic [31:0] mem [0:32767];
   logic drive_reg = 1'b0;
   logic [31:0] q_reg = 32'h0;
   // A read drives its word one cycle after select; writes merge enabled bytes.
   always @(posedge sys_clk) begin
      drive_reg <= !mem_select_n && !mem_out_en_n;
      if (!mem_select_n && !mem_out_en_n) begin
         q_reg <= mem[mem_word_addr];
      end else if (!mem_select_n) begin
         for (int b = 0; b < 4; b++)
            if (!mem_byte_wr_en_n[b]) mem[mem_word_addr][8*b+:8] <= mem_wr_data[8*b+:8];
      end else begin
         q_reg <= ~q_reg;
      end
   end
   // Released lines show the inverse, so a stale word never passes for fresh data.
   assign mem_rd_data = drive_reg ? q_reg : ~q_reg;
endmodule : lbsc_sram_model
`default_nettype wire

// ==== bench/lbsc_top_tb_top.sv ====
// Self-checking bench for the SRAM controller, arbiter and select decode.
// Assumes the SRAM model beside it and the package of the design.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end
module lbsc_top_tb_top;
   import lbsc_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   lbsc_local_req_type req;
   logic [31:0] ld_in = 32'h0;
   logic hold_req = 1'b0;
   logic [1:0] mreq = 2'b00;
   logic [31:0] rd_data, wr_data, ld_out, a;
   logic ld_oe_n, ready_n, stop_n, hold_ack, opt_n, sel_n, oe_n, doe_n;
   logic [1:0] grant;
   logic [2:0] spare_n, exp_sp;
   logic [3:0] bw_n;
   logic [14:0] waddr;
   int mismatches = 0;
   int comparisons = 0;
   logic [31:0] model [int];
   lbsc_top #(.STOP_AT_PAGE_END(1'b1), .MIRROR_AT_ZERO(1'b0)) u_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .local_req(req), .local_data_bus_in(ld_in),
      .local_data_bus_out(ld_out), .local_data_oe_n(ld_oe_n), .ready_n(ready_n),
      .burst_stop_n(stop_n), .bridge_hold_req(hold_req), .master_request(mreq),
      .bridge_hold_ack(hold_ack), .master_grant(grant), .option_module_select_n(opt_n),
      .spare_select_n(spare_n), .mem_select_n(sel_n), .mem_out_en_n(oe_n),
      .mem_byte_wr_en_n(bw_n), .mem_word_addr(waddr), .mem_rd_data(rd_data),
      .mem_wr_data(wr_data), .mem_data_oe_n(doe_n));
   lbsc_sram_model u_sram (.sys_clk(sys_clk), .mem_select_n(sel_n), .mem_out_en_n(oe_n),
      .mem_byte_wr_en_n(bw_n), .mem_word_addr(waddr), .mem_wr_data(wr_data),
      .mem_rd_data(rd_data));
   // Free-running bus clock, 50 ns period.
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("Compared %0d, mismatched %0d.", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   // One burst with random stalls; each completed read phase is checked against the model, each write phase updates it.
   task automatic burst(input logic wr, input logic [31:0] ad, input int n, input logic full);
      logic [14:0] w;
      logic [31:0] d;
      int done;
      int guard;
      w = ad[16:2];
      done = 0;
      guard = 0;
      @(negedge sys_clk);
      req.local_addr = ad;
      req.write = wr;
      req.addr_strobe_n = 1'b0;
      @(negedge sys_clk);
      req.addr_strobe_n = 1'b1;
      while (done < n && guard < 200) begin
         req.accept = ($urandom_range(0, 3) != 0);
         req.last_n = (done != n - 1);
         req.byte_en_n = full ? 4'h0 : 4'($urandom);
         d = $urandom;
         ld_in = d;
         #20;
         if (!req.accept) `CHK(ready_n, 1'b1)
         if (ready_n === 1'b0) begin
            `CHK(stop_n, (w[10:0] == 11'h7FF) ? 1'b0 : 1'b1)
            if (wr) begin
               for (int b = 0; b < 4; b++)
                  if (!req.byte_en_n[b]) model[int'(w)][8*b+:8] = d[8*b+:8];
            end else begin
               `CHK(ld_out, model[int'(w)])
               `CHK(ld_oe_n, 1'b0)
            end
            w[10:0] = w[10:0] + 11'h1;
            done++;
         end
         guard++;
         @(negedge sys_clk);
      end
      `CHK(done, n)
      req.accept = 1'b0;
      req.last_n = 1'b1;
   endtask : burst
   // Main sequence: reset, bursts, page end, undecoded access, decode, arbitration.
   initial begin
      req = '{32'h0, 1'b1, 1'b0, 4'hF, 1'b1, 1'b0};
      void'($urandom(56));
      repeat (4) @(negedge sys_clk);
      `CHK({sel_n, oe_n, bw_n, doe_n, ready_n, stop_n, hold_ack, grant}, 12'hFF8)
      rst_n = 1'b1;
      a = SRAM_BASE + {15'h0, 4'($urandom), 11'($urandom_range(0, 2000)), 2'b00};
      burst(1'b1, a, 6, 1'b1);
      burst(1'b1, a, 6, 1'b0);
      burst(0, a, 6, 1'b0);
      $display("Burst test done.");
      // Start near the page end so the all-ones phase stops the burst.
      a = SRAM_BASE + {15'h0, 4'($urandom), 11'h7FD, 2'b00};
      burst(1'b1, a, 3, 1'b1);
      burst(0, a, 3, 1'b0);
      $display("Page end test done.");
      @(negedge sys_clk);
      req.local_addr = 32'h0;
      req.addr_strobe_n = 1'b0;
      req.accept = 1'b1;
      @(negedge sys_clk);
      req.addr_strobe_n = 1'b1;
      repeat (12) begin
         `CHK(ready_n, 1'b1)
         @(negedge sys_clk);
      end
      req.accept = 1'b0;
      $display("Undecoded test done.");
      for (int nib = 0; nib < 16; nib++) begin
         @(negedge sys_clk);
         req.local_addr = {4'(nib), 28'($urandom)};
         exp_sp = 3'h7;
         if (nib >= 5 && nib <= 7) exp_sp[nib-5] = 1'b0;
         #1;
         `CHK(opt_n, (nib != 4))
         `CHK(spare_n, exp_sp)
      end
      $display("Decode test done.");
      @(negedge sys_clk);
      hold_req = 1'b1;
      mreq = 2'b11;
      repeat (2) @(negedge sys_clk);
      `CHK({hold_ack, grant}, 3'b100)
      hold_req = 1'b0;
      for (int i = 0; i < 6 && grant === 2'b00; i++) @(negedge sys_clk);
      `CHK({hold_ack, grant}, 3'b001)
      repeat (40) begin
         {hold_req, mreq} = 3'($urandom);
         @(negedge sys_clk);
         `CHK($countones({hold_ack, grant}) <= 1, 1'b1)
      end
      $display("Arbiter test done.");
      close_out();
   end
   // Cuts a hang short well beyond the few hundred cycles the tests need.
   initial begin
      #(50 * 20000);
      mismatches++;
      $display("Watchdog expired.");
      close_out();
   end
endmodule : lbsc_top_tb_top
`default_nettype wire
